//--- shared/fgr_pkg.sv
// constants and types for the fine granularity refresh block
package fgr_pkg;
  typedef enum logic [1:0] {
    FGR_RATE_1X,
    FGR_RATE_2X,
    FGR_RATE_4X
  } fgr_rate_e;

  typedef struct packed {
    logic cs_n;
    logic act_n;
    logic ras_n;
    logic cas_n;
    logic we_n;
    logic bank_group_bit_zero;
  } fgr_cmd_s;

  typedef struct packed {
    fgr_rate_e rate;
    logic [15:0] interval_ns;
    logic [8:0] cycle_ns;
  } fgr_refresh_s;

  localparam logic [2:0] FGR_CODE_FIXED_1X = 3'h0;
  localparam logic [2:0] FGR_CODE_FIXED_2X = 3'h1;
  localparam logic [2:0] FGR_CODE_FIXED_4X = 3'h2;
  localparam logic [2:0] FGR_CODE_FLY_2X = 3'h5;
  localparam logic [2:0] FGR_CODE_FLY_4X = 3'h6;
  localparam logic [2:0] FGR_CODE_RESET = FGR_CODE_FIXED_1X;
  localparam int FGR_FLY_BIT = 2;
  localparam logic [15:0] FGR_REFI_BASE_NS = 16'h1E78;
  localparam logic [8:0] FGR_RFC1_NS = 9'h15E;
  localparam logic [8:0] FGR_RFC2_NS = 9'h104;
  localparam logic [8:0] FGR_RFC4_NS = 9'h0A0;
  localparam int FGR_CLK_PERIOD_NS = 10;
  localparam logic [5:0] FGR_RFC1_CYC = 6'((350 + FGR_CLK_PERIOD_NS - 1) / FGR_CLK_PERIOD_NS);
  localparam logic [5:0] FGR_RFC2_CYC = 6'((260 + FGR_CLK_PERIOD_NS - 1) / FGR_CLK_PERIOD_NS);
  localparam logic [5:0] FGR_RFC4_CYC = 6'((160 + FGR_CLK_PERIOD_NS - 1) / FGR_CLK_PERIOD_NS);
  localparam logic [2:0] FGR_CAL_RESET = 3'h0;
endpackage

//--- logic/fgr_cal_rx.sv
// command/address latency receiver enable
`timescale 1ns/1ps
module fgr_cal_rx
  import fgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // control
  input wire logic [2:0] cal_cycles_i,
  input wire logic cs_n_i,
  // status
  output logic rx_enable_o,
  output logic cmd_strobe_o
);
  logic [2:0] cnt_ff;
  logic [2:0] nxt_cnt;
  logic busy_ff;
  logic nxt_busy;

  always_comb begin
    nxt_cnt = cnt_ff;
    nxt_busy = busy_ff;
    cmd_strobe_o = 1'b0;
    if (cal_cycles_i == 3'h0) begin
      nxt_busy = 1'b0;
      cmd_strobe_o = ~cs_n_i;
    end else if (!cs_n_i) begin
      nxt_busy = 1'b1;
      nxt_cnt = cal_cycles_i;
    end else if (busy_ff) begin
      nxt_cnt = cnt_ff - 3'h1;
      if (cnt_ff == 3'h1) begin
        cmd_strobe_o = 1'b1;
        nxt_busy = 1'b0;
      end
    end
  end

  assign rx_enable_o = (cal_cycles_i == 3'h0) | busy_ff | ~cs_n_i;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cnt_ff <= 3'h0;
      busy_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      busy_ff <= nxt_busy;
    end
  end
endmodule

//--- logic/fgr_refresh.sv
// fine granularity refresh mode and command decode
`timescale 1ns/1ps
module fgr_refresh
  import fgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // command pins
  input wire fgr_cmd_s cmd_i,
  // mode register writes and hot flag
  input wire logic mode_register_three_we_i,
  input wire logic [2:0] mode_register_three_i,
  input wire logic mode_register_four_we_i,
  input wire logic [2:0] mode_register_four_i,
  input wire logic hot_i,
  // refresh outputs
  output logic refresh_o,
  output fgr_refresh_s refresh_info_o,
  output logic refresh_busy_o,
  // status
  output logic [2:0] mode_o,
  output logic per_command_rate_select_o,
  output logic reserved_code_o,
  output logic rx_enable_o
);
  // ********************************
  // pin synchronisers
  // ********************************
  fgr_cmd_s cmd_s1_ff;
  fgr_cmd_s cmd_s2_ff;
  logic hot_s1_ff;
  logic hot_s2_ff;

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cmd_s1_ff <= '1;
      cmd_s2_ff <= '1;
      hot_s1_ff <= 1'b0;
      hot_s2_ff <= 1'b0;
    end else begin
      cmd_s1_ff <= cmd_i;
      cmd_s2_ff <= cmd_s1_ff;
      hot_s1_ff <= hot_i;
      hot_s2_ff <= hot_s1_ff;
    end
  end

  // ********************************
  // command latency
  // ********************************
  logic [2:0] cal_ff;
  logic [2:0] nxt_cal;
  logic cmd_strobe;
  logic is_refresh;

  fgr_cal_rx u_cal_rx (
    .ref_clk_i(ref_clk_i),
    .reset_n_i(reset_n_i),
    .cal_cycles_i(cal_ff),
    .cs_n_i(cmd_s2_ff.cs_n),
    .rx_enable_o(rx_enable_o),
    .cmd_strobe_o(cmd_strobe)
  );

  always_comb begin
    nxt_cal = cal_ff;
    if (mode_register_four_we_i) begin
      nxt_cal = mode_register_four_i;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      cal_ff <= FGR_CAL_RESET;
    end else begin
      cal_ff <= nxt_cal;
    end
  end

  // with latency, the select leads, control pins arrive on the strobe
  assign is_refresh = cmd_strobe & cmd_s2_ff.act_n & ~cmd_s2_ff.ras_n & ~cmd_s2_ff.cas_n & cmd_s2_ff.we_n;

  // ********************************
  // mode register field
  // ********************************
  logic [2:0] mode_ff;
  logic [2:0] nxt_mode;
  logic reserved_ff;
  logic nxt_reserved;
  logic code_legal;
  logic fly;

  // legal granularity codes
  always_comb begin
    code_legal = 1'b0;
    case (mode_register_three_i)
      FGR_CODE_FIXED_1X: code_legal = 1'b1;
      FGR_CODE_FIXED_2X: code_legal = 1'b1;
      FGR_CODE_FIXED_4X: code_legal = 1'b1;
      FGR_CODE_FLY_2X: code_legal = 1'b1;
      FGR_CODE_FLY_4X: code_legal = 1'b1;
      default: code_legal = 1'b0;
    endcase
  end

  always_comb begin
    nxt_mode = mode_ff;
    nxt_reserved = reserved_ff;
    if (mode_register_three_we_i) begin
      nxt_mode = mode_register_three_i;
      nxt_reserved = ~code_legal;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      mode_ff <= FGR_CODE_RESET;
      reserved_ff <= 1'b0;
    end else begin
      mode_ff <= nxt_mode;
      reserved_ff <= nxt_reserved;
    end
  end

  assign fly = mode_ff[FGR_FLY_BIT];

  // ********************************
  // rate selection and timing table
  // ********************************
  fgr_rate_e rate;
  logic [15:0] refi_sel;
  logic [8:0] rfc_sel;
  logic [5:0] rfc_cyc_sel;

  always_comb begin
    rate = FGR_RATE_1X;
    if (mode_ff == FGR_CODE_FIXED_2X) begin
      rate = FGR_RATE_2X;
    end else if (mode_ff == FGR_CODE_FIXED_4X) begin
      rate = FGR_RATE_4X;
    end else if (fly && cmd_s2_ff.bank_group_bit_zero) begin
      rate = (mode_ff == FGR_CODE_FLY_2X) ? FGR_RATE_2X : FGR_RATE_4X;
    end
  end

  // interval and cycle time of the selected rate
  always_comb begin
    refi_sel = FGR_REFI_BASE_NS;
    rfc_sel = FGR_RFC1_NS;
    rfc_cyc_sel = FGR_RFC1_CYC;
    case (rate)
      FGR_RATE_2X: begin
        refi_sel = hot_s2_ff ? (FGR_REFI_BASE_NS >> 2) : (FGR_REFI_BASE_NS >> 1);
        rfc_sel = FGR_RFC2_NS;
        rfc_cyc_sel = FGR_RFC2_CYC;
      end
      FGR_RATE_4X: begin
        refi_sel = hot_s2_ff ? (FGR_REFI_BASE_NS >> 3) : (FGR_REFI_BASE_NS >> 2);
        rfc_sel = FGR_RFC4_NS;
        rfc_cyc_sel = FGR_RFC4_CYC;
      end
      default: begin
        refi_sel = hot_s2_ff ? (FGR_REFI_BASE_NS >> 1) : FGR_REFI_BASE_NS;
        rfc_sel = FGR_RFC1_NS;
        rfc_cyc_sel = FGR_RFC1_CYC;
      end
    endcase
  end

  // ********************************
  // refresh report
  // ********************************
  logic refresh_ff;
  logic nxt_refresh;
  fgr_refresh_s info_ff;
  fgr_refresh_s nxt_info;
  logic [5:0] busy_ff;
  logic [5:0] nxt_busy;

  always_comb begin
    nxt_refresh = is_refresh;
    nxt_info = info_ff;
    nxt_busy = (busy_ff != 6'h0) ? busy_ff - 6'h1 : 6'h0;
    if (is_refresh) begin
      nxt_info = '{rate, refi_sel, rfc_sel};
      nxt_busy = rfc_cyc_sel;
    end
  end

  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) begin
      refresh_ff <= 1'b0;
      info_ff <= '{FGR_RATE_1X, FGR_REFI_BASE_NS, FGR_RFC1_NS};
      busy_ff <= 6'h0;
    end else begin
      refresh_ff <= nxt_refresh;
      info_ff <= nxt_info;
      busy_ff <= nxt_busy;
    end
  end

  // ********************************
  // outputs
  // ********************************
  assign refresh_o = refresh_ff;
  assign refresh_info_o = info_ff;
  assign refresh_busy_o = (busy_ff != 6'h0);
  assign mode_o = mode_ff;
  assign per_command_rate_select_o = fly;
  assign reserved_code_o = reserved_ff;
endmodule

//--- testbench/fgr_chk.sv
// assertions for the refresh block
`timescale 1ns/1ps
module fgr_chk
  import fgr_pkg::*;
(
  // clock and reset
  input wire logic ref_clk_i,
  input wire logic reset_n_i,
  // inputs
  input wire fgr_cmd_s cmd_i,
  input wire logic mode_register_three_we_i,
  input wire logic [2:0] mode_register_three_i,
  input wire logic mode_register_four_we_i,
  input wire logic [2:0] mode_register_four_i,
  input wire logic hot_i,
  // outputs
  input wire logic refresh_o,
  input wire fgr_refresh_s refresh_info_o,
  input wire logic refresh_busy_o,
  input wire logic [2:0] mode_o,
  input wire logic reserved_code_o,
  input wire logic rx_enable_o
);
  logic [2:0] cal_ff;
  logic [8:0] exp_cyc;
  always_ff @(posedge ref_clk_i) begin
    if (!reset_n_i) cal_ff <= 3'h0;
    else if (mode_register_four_we_i) cal_ff <= mode_register_four_i;
  end
  assign exp_cyc = refresh_info_o.rate == FGR_RATE_1X ? FGR_RFC1_NS :
    refresh_info_o.rate == FGR_RATE_2X ? FGR_RFC2_NS : FGR_RFC4_NS;
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!reset_n_i);
  sequence s_ref;
    !cmd_i.cs_n && cmd_i.act_n && !cmd_i.ras_n && !cmd_i.cas_n && cmd_i.we_n && cal_ff == 3'h0;
  endsequence
  sequence s_busy;
    refresh_o ##1 refresh_busy_o [*8];
  endsequence
  property p_ref; s_ref |-> ##[2:4] refresh_o; endproperty
  a_ref: assert property (p_ref) else $error("refresh pins not decoded");
  property p_busy; refresh_o |-> s_busy; endproperty
  a_busy: assert property (p_busy) else $error("busy too short");
  property p_mode; mode_register_three_we_i |=> mode_o == $past(mode_register_three_i); endproperty
  a_mode: assert property (p_mode) else $error("mode not loaded");
  property p_rsv;
    mode_register_three_we_i |=> reserved_code_o == ($past(mode_register_three_i) inside {3'h3, 3'h4, 3'h7});
  endproperty
  a_rsv: assert property (p_rsv) else $error("reserved flag wrong");
  property p_rate; refresh_o && !mode_o[2] |-> refresh_info_o.rate == fgr_rate_e'(mode_o[1:0]); endproperty
  a_rate: assert property (p_rate) else $error("fixed rate wrong");
  property p_cyc; refresh_o |-> refresh_info_o.cycle_ns == exp_cyc; endproperty
  a_cyc: assert property (p_cyc) else $error("cycle time wrong");
  property p_int; refresh_o |-> refresh_info_o.interval_ns == FGR_REFI_BASE_NS >> (refresh_info_o.rate + hot_i); endproperty
  a_int: assert property (p_int) else $error("interval wrong");
  property p_rx; cal_ff == 3'h0 |-> rx_enable_o; endproperty
  a_rx: assert property (p_rx) else $error("receivers off");
  property p_rx_on; !cmd_i.cs_n && cal_ff != 3'h0 |-> ##2 rx_enable_o [*2]; endproperty
  a_rx_on: assert property (p_rx_on) else $error("receivers not enabled after select");
endmodule

//--- testbench/fgr_ctrl_model.sv
// controller-side model driving refresh commands
`timescale 1ns/1ps
module fgr_ctrl_model
  import fgr_pkg::*;
(
  // clock
  input wire logic ref_clk_i,
  // request
  input wire logic go_i,
  input wire logic bg_i,
  input wire logic [2:0] cal_i,
  // pins
  output fgr_cmd_s cmd_o
);
  logic [2:0] wait_ff = 3'h0;
  initial cmd_o = 6'h3F;
  always @(posedge ref_clk_i) begin
    if (go_i && cal_i != 3'h0) begin
      cmd_o <= 6'h1F;
      wait_ff <= cal_i;
    end else begin
      wait_ff <= (wait_ff != 3'h0) ? wait_ff - 3'h1 : 3'h0;
      if (go_i || wait_ff == 3'h1) begin
        cmd_o <= {!go_i, 4'h9, bg_i};
      end else begin
        // deselect: idle pins change every cycle
        cmd_o <= {1'b1, ~cmd_o[4:0]};
      end
    end
  end
endmodule

//--- testbench/fgr_tb.sv
// self-checking bench for the refresh block
`timescale 1ns/1ps
module testbench;
  import fgr_pkg::*;
  logic ref_clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic wr_three = 1'b0;
  logic wr_four = 1'b0;
  logic hot = 1'b0;
  logic go = 1'b0;
  logic bg = 1'b0;
  logic [2:0] code = 3'h0;
  logic [2:0] cal = 3'h0;
  logic refresh, busy, rsv, fly, rx_en;
  logic [2:0] mode;
  fgr_cmd_s cmd;
  fgr_refresh_s info;
  int failures = 0;
  int n_tests = 0;
  always #5 ref_clk_i = ~ref_clk_i;
  fgr_ctrl_model ctrl (.ref_clk_i(ref_clk_i), .go_i(go), .bg_i(bg), .cal_i(cal), .cmd_o(cmd));
  fgr_refresh dut (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i), .cmd_i(cmd), .mode_register_three_we_i(wr_three),
    .mode_register_three_i(code), .mode_register_four_we_i(wr_four), .mode_register_four_i(cal), .hot_i(hot),
    .refresh_o(refresh), .refresh_info_o(info), .refresh_busy_o(busy), .mode_o(mode),
    .per_command_rate_select_o(fly), .reserved_code_o(rsv), .rx_enable_o(rx_en));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("[ERR] t=%0t seen %0h expected %0h", $time, seen, exp);
    end
  endtask
  task automatic results;
    $display("checks %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic set_mode(input logic [2:0] c);
    @(posedge ref_clk_i);
    code <= c;
    wr_three <= 1'b1;
    @(posedge ref_clk_i);
    wr_three <= 1'b0;
    @(negedge ref_clk_i);
    chk(mode, c);
    chk(rsv, c inside {3'h3, 3'h4, 3'h7});
    chk(fly, c[2]);
  endtask
  task automatic ref1(input logic b, input fgr_rate_e r);
    int k;
    @(posedge ref_clk_i);
    bg <= b;
    go <= 1'b1;
    @(posedge ref_clk_i);
    go <= 1'b0;
    for (k = 0; refresh !== 1'b1 && k < 20; k++) @(negedge ref_clk_i);
    chk(refresh, 1'b1);
    chk(info.rate, r);
    chk(info.interval_ns, FGR_REFI_BASE_NS >> (r + hot));
    for (k = 0; busy !== 1'b0 && k < 50; k++) @(negedge ref_clk_i);
  endtask
  initial begin
    repeat (8) @(posedge ref_clk_i);
    reset_n_i <= 1'b1;
    @(negedge ref_clk_i);
    chk(mode, 3'h0);
    chk(info, {FGR_RATE_1X, FGR_REFI_BASE_NS, FGR_RFC1_NS});
    chk(rx_en, 1'b1);
    ref1(1'b1, FGR_RATE_1X);
    for (int m = 1; m < 3; m++) begin
      set_mode(3'(m));
      repeat (2 * m) ref1(m[0], fgr_rate_e'(m));
    end
    for (int m = 5; m < 7; m++) begin
      set_mode(3'(m));
      ref1(1'b0, FGR_RATE_1X);
      repeat (2 * m - 8) ref1(1'b1, fgr_rate_e'(m - 4));
      ref1(1'b0, FGR_RATE_1X);
    end
    set_mode(3'h3);
    set_mode(3'h4);
    set_mode(3'h7);
    set_mode(3'h0);
    @(posedge ref_clk_i);
    hot <= 1'b1;
    repeat (4) @(posedge ref_clk_i);
    ref1(1'b1, FGR_RATE_1X);
    @(posedge ref_clk_i);
    cal <= 3'h3;
    wr_four <= 1'b1;
    @(posedge ref_clk_i);
    wr_four <= 1'b0;
    @(negedge ref_clk_i);
    chk(rx_en, 1'b0);
    ref1(1'b0, FGR_RATE_1X);
    chk(rx_en, 1'b0);
    results;
  end
  // whole run is about 600 cycles
  initial begin
    #100000;
    failures++;
    results;
  end
endmodule
bind fgr_refresh fgr_chk chk (.*);
